//--- rtl/spi_err_pkg.sv
// Constants for the serial access error checks
package spi_err_pkg;
  localparam int REG_COUNT = 8;
  localparam int ADDR_W = 7;
  localparam int CNT_W = 8;
  localparam int SH_W = 24;
  localparam logic [ADDR_W-1:0] EN_REG_ADDR = 7'h00;
  localparam logic [ADDR_W-1:0] STAT_REG_ADDR = 7'h01;
  localparam int EN_PULSE_BIT = 5;
  localparam int EN_READ_BIT = 4;
  localparam int EN_WRITE_BIT = 3;
  localparam int EN_CRC_BIT = 2;
  localparam logic [7:0] EN_RESET = 8'h00;
  localparam logic [7:0] EN_MASK = 8'h3c;
  localparam logic [REG_COUNT-1:0] RO_MASK = 8'h02;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;
  localparam logic [CNT_W-1:0] CMD_BITS = 8'd8;
  localparam logic [CNT_W-1:0] FRAME_PLAIN = 8'd16;
  localparam logic [CNT_W-1:0] FRAME_CRC = 8'd24;
  localparam int FLAG_PULSE = 0;
  localparam int FLAG_READ = 1;
  localparam int FLAG_WRITE = 2;
  localparam int FLAG_CRC = 3;
  localparam int CMD_READ_BIT = 7;
endpackage : spi_err_pkg

//--- rtl/spi_access_error_checks.sv
// Serial register port with pulse-count, address and checksum checks
// How it works
// RULE_01 - Pulse check needs its enable and chip-select enable
// RULE_02 - Host frames every access with chip select
// RULE_03 - Pulse count not multiple of eight sets flag
// RULE_04 - Short write aborts, register keeps old value
// RULE_05 - Reading nonexistent address sets read flag
// RULE_06 - Writing nonexistent or read-only address sets flag
// RULE_07 - Checksum gates writes and accompanies read data
// RULE_08 - Check enables are read-write, one enables
// RULE_09 - Write checksum mismatch sets checksum flag
`timescale 1ns/10ps
module spi_access_error_checks
  import spi_err_pkg::*;
(
  // System clock and reset
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // Serial link
  input wire logic i_sclk_link,
  input wire logic i_cs_n,
  input wire logic i_sdi,
  output logic o_sdo,
  output logic o_sdo_oe,
  // Configuration
  input wire logic i_chip_select_use_enable,
  input wire logic i_cfg_wr,
  input wire logic [7:0] i_cfg_wdata,
  output logic [7:0] o_check_enable,
  // Error flags
  input wire logic [3:0] i_err_clear,
  output logic o_pulse_count_error_flag,
  output logic o_read_error_flag,
  output logic o_write_error_flag,
  output logic o_checksum_error_flag,
  // Register contents
  output logic [REG_COUNT-1:0][7:0] o_regs
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [SH_W-1:0] sh;
  } link_t;

  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic cs_s3;
    logic [CNT_W-1:0] cnt_s1;
    logic [CNT_W-1:0] cnt_s2;
    logic [SH_W-1:0] sh_s1;
    logic [SH_W-1:0] sh_s2;
    logic [CNT_W-1:0] base;
    logic [REG_COUNT-1:0][7:0] regs;
    logic [3:0] flags;
  } sys_t;

  link_t lk_r;
  link_t lk_nxt;
  sys_t sy_r;
  sys_t sy_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Functions
  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    logic fb;
    c = CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      fb = c[7] ^ d[i];
      c = {c[6:0], 1'b0};
      if (fb) begin
        c = c ^ CRC_POLY;
      end
    end
    return c;
  endfunction : crc8

  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    return 32'(a) < REG_COUNT;
  endfunction : addr_ok

  function automatic logic gated(input logic [7:0] en, input int b, input logic cs_use);
    return en[b] & cs_use;
  endfunction : gated

  function automatic logic wr_refused(input logic [ADDR_W-1:0] a);
    return !addr_ok(a) || RO_MASK[a[2:0]];
  endfunction : wr_refused

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: count pulses and shift in
  logic [CNT_W-1:0] lk_pos;
  logic [7:0] lk_cmd;
  logic [7:0] lk_rdata;
  logic [15:0] lk_tx;
  logic [CNT_W-1:0] lk_idx;
  logic crc_on;

  assign crc_on = sy_r.regs[EN_REG_ADDR][EN_CRC_BIT];

  always_comb begin
    lk_nxt = lk_r;
    lk_nxt.cnt = lk_r.cnt + 8'd1;
    lk_nxt.sh = {lk_r.sh[SH_W-2:0], i_sdi};
    // Base changes only while the link clock is idle; registers also change on i_cfg_wr and i_err_clear at any time
    lk_pos = lk_r.cnt - sy_r.base;
    lk_cmd = 8'(lk_r.sh >> (lk_pos - CMD_BITS));
    lk_rdata = addr_ok(lk_cmd[ADDR_W-1:0]) ? sy_r.regs[lk_cmd[2:0]] : 8'h00; // RULE_05
    lk_tx = {lk_rdata, crc_on ? crc8({lk_cmd, lk_rdata}) : 8'h00}; // RULE_07
    lk_idx = (FRAME_CRC - 8'd1) - lk_pos;
    o_sdo_oe = 1'b0;
    o_sdo = 1'b0;
    if (lk_pos >= CMD_BITS && lk_pos < FRAME_CRC && lk_cmd[CMD_READ_BIT]) begin
      o_sdo_oe = 1'b1;
      o_sdo = lk_tx[lk_idx[3:0]];
    end
  end

  // Reset needs link edges while low
  always_ff @(posedge i_sclk_link) begin
    if (!i_nrst) begin
      lk_r <= '0;
    end else begin
      lk_r <= lk_nxt; // RULE_03
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // System domain: frame evaluation
  logic frame_end;
  logic [CNT_W-1:0] diff;
  logic [7:0] cmd;
  logic [7:0] wdata;
  logic [7:0] wcrc;
  logic [CNT_W-1:0] exp_len;
  logic [3:0] set;
  logic [ADDR_W-1:0] addr;
  logic pulse_on;
  logic read_on;
  logic write_on;

  // Checks gated by chip-select enable
  assign pulse_on = gated(sy_r.regs[EN_REG_ADDR], EN_PULSE_BIT, i_chip_select_use_enable);
  assign read_on = gated(sy_r.regs[EN_REG_ADDR], EN_READ_BIT, i_chip_select_use_enable);
  assign write_on = gated(sy_r.regs[EN_REG_ADDR], EN_WRITE_BIT, i_chip_select_use_enable);

  always_comb begin
    sy_nxt = sy_r;
    set = 4'h0;
    sy_nxt.cs_s1 = i_cs_n;
    sy_nxt.cs_s2 = sy_r.cs_s1;
    sy_nxt.cs_s3 = sy_r.cs_s2;
    sy_nxt.cnt_s1 = lk_r.cnt;
    sy_nxt.cnt_s2 = sy_r.cnt_s1;
    sy_nxt.sh_s1 = lk_r.sh;
    sy_nxt.sh_s2 = sy_r.sh_s1;
    frame_end = sy_r.cs_s2 & ~sy_r.cs_s3;
    diff = sy_r.cnt_s2 - sy_r.base;
    cmd = 8'(sy_r.sh_s2 >> (diff - CMD_BITS));
    addr = cmd[ADDR_W-1:0];
    exp_len = crc_on ? FRAME_CRC : FRAME_PLAIN;
    wdata = crc_on ? sy_r.sh_s2[15:8] : sy_r.sh_s2[7:0];
    wcrc = sy_r.sh_s2[7:0];
    if (i_cfg_wr) begin
      sy_nxt.regs[EN_REG_ADDR] = i_cfg_wdata & EN_MASK; // RULE_08
    end
    if (frame_end && diff != 8'd0) begin
      sy_nxt.base = sy_r.cnt_s2;
      if (pulse_on && diff[2:0] != 3'h0) begin // RULE_01
        set[FLAG_PULSE] = 1'b1; // RULE_03
      end
      if (diff >= CMD_BITS && diff <= FRAME_CRC) begin
        if (cmd[CMD_READ_BIT]) begin
          if (!addr_ok(addr) && read_on) begin
            set[FLAG_READ] = 1'b1; // RULE_05
          end
        end else if (diff == exp_len) begin // RULE_04
          if (wr_refused(addr)) begin
            set[FLAG_WRITE] = write_on; // RULE_06
          end else if (crc_on && crc8({cmd, wdata}) != wcrc) begin
            set[FLAG_CRC] = 1'b1; // RULE_09
          end else if (addr == EN_REG_ADDR) begin
            sy_nxt.regs[EN_REG_ADDR] = wdata & EN_MASK; // RULE_08
          end else begin
            sy_nxt.regs[addr[2:0]] = wdata; // RULE_07
          end
        end
      end
    end
    sy_nxt.flags = (sy_r.flags & ~i_err_clear) | set;
    sy_nxt.regs[STAT_REG_ADDR] = {4'h0, sy_nxt.flags};
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      sy_r <= '0;
      sy_r.cs_s1 <= 1'b1;
      sy_r.cs_s2 <= 1'b1;
      sy_r.cs_s3 <= 1'b1;
      sy_r.regs <= {REG_COUNT{REG_RESET}};
      sy_r.regs[EN_REG_ADDR] <= EN_RESET;
    end else begin
      sy_r <= sy_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign o_check_enable = sy_r.regs[EN_REG_ADDR];
  assign o_pulse_count_error_flag = sy_r.flags[FLAG_PULSE];
  assign o_read_error_flag = sy_r.flags[FLAG_READ];
  assign o_write_error_flag = sy_r.flags[FLAG_WRITE];
  assign o_checksum_error_flag = sy_r.flags[FLAG_CRC];
  assign o_regs = sy_r.regs;

endmodule : spi_access_error_checks

//--- bench/spi_host_model.sv
// Serial host model
`timescale 1ns/10ps
module spi_host_model (
  output logic o_sclk = 1'b0,
  output logic o_cs_n = 1'b1,
  output logic o_sdi = 1'b0,
  input wire logic i_sdo
);
  // Link flops reset only on link edges, so pulse the clock while reset is low
  task automatic reset_pulses();
    repeat (2) begin
      #4 o_sclk = 1'b1;
      #4 o_sclk = 1'b0;
    end
  endtask : reset_pulses
  task automatic xfer(input int n, input logic [23:0] d, output logic [23:0] q);
    q = '0;
    #1.3 o_cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      o_sdi = d[23-i];
      #16 q = {q[22:0], i_sdo};
      o_sclk = 1'b1;
      #16 o_sclk = 1'b0;
    end
    #8 o_cs_n = 1'b1;
    o_sdi = ~o_sdi;
    #40;
  endtask : xfer
endmodule : spi_host_model

//--- bench/spi_access_error_checks_asserts.sv
// Port assertions
`timescale 1ns/10ps
module spi_access_error_checks_asserts (
  input wire logic i_clk_sys, i_nrst, i_cs_n, i_chip_select_use_enable, i_cfg_wr,
  input wire logic [7:0] i_cfg_wdata, o_check_enable,
  input wire logic o_pulse_count_error_flag, o_read_error_flag,
  input wire logic o_write_error_flag, o_checksum_error_flag,
  input wire logic [7:0][7:0] o_regs
);
  wire [7:0] e = o_check_enable;
  wire c = i_chip_select_use_enable;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  cfg_load_a: assert property (i_cfg_wr |=> e == ($past(i_cfg_wdata) & 8'h3c))
    else $error("cfg");
  en_mask_a: assert property ((e & 8'hc3) == 8'h00) else $error("mask");
  pulse_gate_a: assert property ($rose(o_pulse_count_error_flag) |-> e[5] && c)
    else $error("pulse");
  pulse_late_a: assert property ($rose(o_pulse_count_error_flag) |-> $past(i_cs_n, 2))
    else $error("late");
  rd_gate_a: assert property ($rose(o_read_error_flag) |-> e[4] && c)
    else $error("rd");
  wr_gate_a: assert property ($rose(o_write_error_flag) |-> e[3] && c)
    else $error("wr");
  crc_gate_a: assert property ($rose(o_checksum_error_flag) |-> e[2])
    else $error("crc");
  reg_hold_a: assert property (!i_cs_n |=> $stable(o_regs[7:2]))
    else $error("reg");
  cover property ($rose(o_pulse_count_error_flag));
  cover property ($rose(o_checksum_error_flag));
  cover property (i_cfg_wr);
endmodule : spi_access_error_checks_asserts
bind spi_access_error_checks spi_access_error_checks_asserts chk_u (.*);

//--- bench/spi_access_error_checks_test.sv
// Bench
`timescale 1ns/10ps
module spi_access_error_checks_test;
  logic i_clk_sys = 0, i_nrst = 0, i_chip_select_use_enable = 0, i_cfg_wr = 0;
  logic [7:0] i_cfg_wdata = 0, v;
  logic [3:0] i_err_clear = 0;
  wire i_sclk_link, i_cs_n, i_sdi, o_sdo, o_sdo_oe, o_pulse_count_error_flag;
  wire o_read_error_flag, o_write_error_flag, o_checksum_error_flag;
  wire [7:0] o_check_enable;
  wire [7:0][7:0] o_regs;
  int num_errors = 0, cmp_count = 0;
  logic [31:0] s = 32'hc0d18b18;
  logic [23:0] q;
  always #2 i_clk_sys = ~i_clk_sys;
  spi_access_error_checks dut_u (.*);
  spi_host_model host_u (.o_sclk(i_sclk_link), .o_cs_n(i_cs_n), .o_sdi(i_sdi), .i_sdo(o_sdo));
  function automatic logic [7:0] rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s[7:0];
  endfunction : rnd
  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] k = 8'h00;
    for (int i = 15; i >= 0; i--) k = {k[6:0], 1'b0} ^ (k[7] ^ d[i] ? 8'h07 : 8'h00);
    return k;
  endfunction : crc8
  task automatic chk(input string n, input logic [15:0] x, e);
    cmp_count++;
    if (x !== e) begin
      num_errors++;
      $display("[ERR] %s exp %h seen %h", n, e, x);
    end
  endtask : chk
  task automatic cfg(input logic [7:0] x);
    @(posedge i_clk_sys) i_cfg_wr <= 1;
    i_cfg_wdata <= x;
    @(posedge i_clk_sys) i_cfg_wr <= 0;
    @(posedge i_clk_sys) chk("en", o_check_enable, x & 8'h3c);
  endtask : cfg
  task automatic fr(input int n, input logic [23:0] d, input logic [3:0] f);
    host_u.xfer(n, d, q);
    @(posedge i_clk_sys) chk("flags", {o_checksum_error_flag, o_write_error_flag,
      o_read_error_flag, o_pulse_count_error_flag}, f);
    i_err_clear <= 4'hf;
    @(posedge i_clk_sys) i_err_clear <= 0;
  endtask : fr
  task automatic summarize();
    $display("errors %0d of %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  initial begin
    #50000;
    num_errors++;
    summarize();
  end
  initial begin
    fork
      host_u.reset_pulses();
      repeat (6) @(posedge i_clk_sys);
    join
    i_nrst <= 1;
    @(posedge i_clk_sys) chk("en", o_check_enable, 0);
    cfg(rnd());
    cfg(8'h38);
    i_chip_select_use_enable <= 1;
    v = rnd();
    for (int a = 2; a < 8; a++) fr(16, {a[7:0], v ^ a[7:0], 8'h00}, 0);
    fr(12, 24'h03a500, 1);
    chk("reg", o_regs[3], v ^ 8'h03);
    fr(24, 24'h850000, 0);
    chk("rd", q[15:0], {v ^ 8'h05, 8'h00});
    fr(24, 24'h900000, 2);
    fr(16, 24'h01ff00, 4);
    i_chip_select_use_enable <= 0;
    fr(12, 24'h04a500, 0);
    cfg(8'h04);
    fr(24, {8'h06, v, crc8({8'h06, v})}, 0);
    fr(24, {8'h06, ~v, crc8({8'h06, v})}, 8);
    chk("crc", o_regs[6], v);
    summarize();
  end
endmodule : spi_access_error_checks_test
